// file: rtl/circular_buffer_address_modulo.v
`timescale 1ns/1ps
`include "circ_addr_consts.vh"

module circular_buffer_address_modulo #(
  parameter ADDR_WIDTH = 16,
  parameter SEL_WIDTH  = 4
) (
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  reset,
  // apb slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // effective address update from the core
  input  wire                  eaValid,
  input  wire                  eaSpaceY,
  input  wire                  eaWrite,
  input  wire [SEL_WIDTH-1:0]  eaReg,
  input  wire [ADDR_WIDTH-1:0] eaValue,
  input  wire [ADDR_WIDTH-1:0] eaStep,
  // updated pointer back to the core
  output reg                   resultValid,
  output reg  [SEL_WIDTH-1:0]  resultReg,
  output reg  [ADDR_WIDTH-1:0] resultValue,
  output reg                   resultWrapped,
  output reg                   resultWrite
);

  // ----------------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------------
  // inclusive byte length of a buffer from its two bounds
  function [16:0] bufferLength;
    input [15:0] startAddr;
    input [15:0] endAddr;
    begin
      bufferLength = {1'b0, endAddr} - {1'b0, startAddr} + 17'h00001;
    end
  endfunction

  // length counted in words is a power of two
  function isPow2;
    input [16:0] lenBytes;
    reg   [16:0] words;
    begin
      words  = {1'b0, lenBytes[16:1]};
      isPow2 = (words != 17'h00000) && ((words & (words - 17'h00001)) == 17'h00000) && !lenBytes[0];
    end
  endfunction

  // length fits the largest allowed buffer
  function lengthOk;
    input [15:0] startAddr;
    input [15:0] endAddr;
    begin
      lengthOk = (endAddr >= startAddr) && (bufferLength(startAddr, endAddr) <= `MAX_LEN_BYTES);
    end
  endfunction

  // clears bit 0 for word-sized y space accesses
  function [15:0] wordAlign;
    input [15:0] addr;
    begin
      wordAlign = {addr[15:1], 1'b0};
    end
  endfunction

  // upward step passes the end bound or rolls over the top of the space
  function passesHigh;
    input [15:0] base;
    input [15:0] sum;
    input [15:0] high;
    begin
      passesHigh = (sum > high) || (sum < base);
    end
  endfunction

  // downward step passes the start bound or rolls under zero
  function passesLow;
    input [15:0] base;
    input [15:0] sum;
    input [15:0] low;
    begin
      passesLow = (sum < low) || (sum > base);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  reg  [15:0] circular_addressing_control;
  reg  [15:0] x_buffer_start_address;
  reg  [15:0] x_buffer_end_address;
  reg  [15:0] y_buffer_start_address;
  reg  [15:0] y_buffer_end_address;
  reg         lastWrap;

  wire [SEL_WIDTH-1:0] x_pointer_select;
  wire [SEL_WIDTH-1:0] y_pointer_select;
  wire                 x_circular_enable;
  wire                 y_circular_enable;
  wire                 xActive;
  wire                 yActive;

  assign x_pointer_select  = circular_addressing_control[`CTL_X_SEL_MSB:`CTL_X_SEL_LSB];
  assign y_pointer_select  = circular_addressing_control[`CTL_Y_SEL_MSB:`CTL_Y_SEL_LSB];
  assign x_circular_enable = circular_addressing_control[`CTL_X_EN_BIT];
  assign y_circular_enable = circular_addressing_control[`CTL_Y_EN_BIT];

  // select of 15 disables the generator whatever the enable bit says
  assign xActive = x_circular_enable && (x_pointer_select != `SEL_DISABLED);
  assign yActive = y_circular_enable && (y_pointer_select != `SEL_DISABLED);

  // ----------------------------------------------------------------------------
  // buffer length status, implied by the bounds
  // ----------------------------------------------------------------------------
  wire [16:0] xLength;
  wire [16:0] yLength;
  wire        xPow2;
  wire        yPow2;
  wire        xLengthOk;
  wire        yLengthOk;

  assign xLength   = bufferLength(x_buffer_start_address, x_buffer_end_address);
  assign yLength   = bufferLength(y_buffer_start_address, y_buffer_end_address);
  assign xPow2     = isPow2(xLength);
  assign yPow2     = isPow2(yLength);
  assign xLengthOk = lengthOk(x_buffer_start_address, x_buffer_end_address);
  assign yLengthOk = lengthOk(y_buffer_start_address, y_buffer_end_address);

  // ----------------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------------
  wire        setupPhase;
  wire        accessDone;
  wire        addrMapped;
  wire [15:0] statusWord;
  reg  [15:0] readWord;

  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign addrMapped = (paddr == `OFS_CONTROL) || (paddr == `OFS_X_START) || (paddr == `OFS_X_END) ||
                      (paddr == `OFS_Y_START) || (paddr == `OFS_Y_END) || (paddr == `OFS_STATUS);

  assign statusWord = {9'h000,
                       lastWrap,
                       yLengthOk,
                       xLengthOk,
                       yPow2,
                       xPow2,
                       yActive,
                       xActive};

  always @*
  begin
    case (paddr)
      `OFS_CONTROL: readWord = circular_addressing_control;
      `OFS_X_START: readWord = x_buffer_start_address;
      `OFS_X_END:   readWord = x_buffer_end_address;
      `OFS_Y_START: readWord = y_buffer_start_address;
      `OFS_Y_END:   readWord = y_buffer_end_address;
      `OFS_STATUS:  readWord = statusWord;
      default:      readWord = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------------
  // apb handshake: answer ready in the first access cycle
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (setupPhase)
    begin
      pready  <= 1'b1;
      pslverr <= !addrMapped;
      prdata  <= pwrite ? 32'h00000000 : {16'h0000, readWord};
    end
    else if (accessDone)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // register writes, taken only at the completing access edge
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      circular_addressing_control <= `RST_CONTROL;
      x_buffer_start_address      <= `RST_ADDRESS;
      x_buffer_end_address        <= `RST_ADDRESS;
      y_buffer_start_address      <= `RST_ADDRESS;
      y_buffer_end_address        <= `RST_ADDRESS;
    end
    else if (accessDone && pwrite)
    begin
      case (paddr)
        `OFS_CONTROL: circular_addressing_control <= pwdata[15:0] & `CTL_WRITE_MASK;
        `OFS_X_START: x_buffer_start_address      <= pwdata[15:0];
        `OFS_X_END:   x_buffer_end_address        <= pwdata[15:0];
        `OFS_Y_START: y_buffer_start_address      <= pwdata[15:0];
        `OFS_Y_END:   y_buffer_end_address        <= pwdata[15:0];
        default:      circular_addressing_control <= circular_addressing_control;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // per-space bounds, y space reloads land on word addresses
  // ----------------------------------------------------------------------------
  wire [15:0] xLow;
  wire [15:0] xHigh;
  wire [15:0] yLow;
  wire [15:0] yHigh;
  wire [15:0] yReload;

  assign xLow    = x_buffer_start_address;
  assign xHigh   = x_buffer_end_address;
  assign yLow    = wordAlign(y_buffer_start_address);
  assign yHigh   = y_buffer_end_address;
  assign yReload = wordAlign(y_buffer_end_address);

  // ----------------------------------------------------------------------------
  // pointer update path
  // ----------------------------------------------------------------------------
  reg  [15:0] lowBound;
  reg  [15:0] highBound;
  reg  [15:0] reloadHigh;
  reg  [15:0] baseValue;
  reg  [15:0] stepValue;
  reg  [15:0] sumValue;
  reg         applies;
  reg         goingDown;
  reg         overHigh;
  reg         underLow;
  reg  [15:0] next_value;
  reg         next_wrap;

  always @*
  begin
    lowBound   = 16'h0000;
    highBound  = 16'hffff;
    reloadHigh = 16'hffff;
    baseValue  = eaValue;
    stepValue  = eaStep;
    applies    = 1'b0;
    // one buffer per space; eaSpaceY picks the Y generator, otherwise the X generator
    if (eaSpaceY)
    begin
      applies    = yActive && (eaReg == y_pointer_select);
      lowBound   = yLow;
      highBound  = yHigh;
      reloadHigh = yReload;
      baseValue  = wordAlign(eaValue);
      stepValue  = wordAlign(eaStep);
    end
    else
    begin
      // read and write generators share the same selection and bounds
      applies    = xActive && (eaReg == x_pointer_select);
      lowBound   = xLow;
      highBound  = xHigh;
      reloadHigh = xHigh;
    end
    goingDown = stepValue[15];
    sumValue  = baseValue + stepValue;
    // length is implied by the bounds; only the edge in the step direction is checked
    overHigh  = !goingDown && passesHigh(baseValue, sumValue, highBound);
    underLow  = goingDown && passesLow(baseValue, sumValue, lowBound);
    next_wrap = 1'b0;
    if (!applies)
    begin
      next_value = sumValue;
    end
    else if (overHigh)
    begin
      next_value = lowBound;
      next_wrap  = 1'b1;
    end
    else if (underLow)
    begin
      next_value = reloadHigh;
      next_wrap  = 1'b1;
    end
    else
    begin
      next_value = sumValue;
    end
  end

  // ----------------------------------------------------------------------------
  // result register, one cycle after the request
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      resultValid   <= 1'b0;
      resultReg     <= {SEL_WIDTH{1'b0}};
      resultValue   <= 16'h0000;
      resultWrapped <= 1'b0;
      resultWrite   <= 1'b0;
      lastWrap      <= 1'b0;
    end
    else
    begin
      resultValid <= eaValid;
      if (eaValid)
      begin
        resultReg     <= eaReg;
        resultValue   <= next_value;
        resultWrapped <= next_wrap;
        resultWrite   <= eaWrite;
        lastWrap      <= next_wrap;
      end
      else
      begin
        resultWrapped <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/circ_addr_consts.vh
`ifndef CIRC_ADDR_CONSTS_VH
`define CIRC_ADDR_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL      12'h000
`define OFS_X_START      12'h004
`define OFS_X_END        12'h008
`define OFS_Y_START      12'h00c
`define OFS_Y_END        12'h010
`define OFS_STATUS       12'h014

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTL_X_SEL_LSB    0
`define CTL_X_SEL_MSB    3
`define CTL_Y_SEL_LSB    4
`define CTL_Y_SEL_MSB    7
`define CTL_Y_EN_BIT     14
`define CTL_X_EN_BIT     15
`define CTL_WRITE_MASK   16'hc0ff
`define SEL_DISABLED     4'hf

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define STA_X_ACTIVE     0
`define STA_Y_ACTIVE     1
`define STA_X_POW2       2
`define STA_Y_POW2       3
`define STA_X_LEN_OK     4
`define STA_Y_LEN_OK     5
`define STA_LAST_WRAP    6

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define RST_CONTROL      16'h0000
`define RST_ADDRESS      16'h0000
`define MAX_LEN_BYTES    17'h10000

`endif

// file: tb/core_update_model.sv
`timescale 1ns/1ps
module core_update_model (
  // clock
  input  wire         clk_sys,
  // update request towards the block
  output logic        eaValid,
  output logic        eaSpaceY,
  output logic        eaWrite,
  output logic [3:0]  eaReg,
  output logic [15:0] eaValue,
  output logic [15:0] eaStep
);
  initial
  begin
    eaValid  = 1'b0;
    eaSpaceY = 1'b0;
    eaWrite  = 1'b0;
    eaReg    = 4'h0;
    eaValue  = 16'h0000;
    eaStep   = 16'h0000;
  end

  // one pointer update for any working register
  task automatic issue(input logic y, input logic w, input logic [3:0] r, input logic [15:0] v,
                       input logic [15:0] s);
    @(posedge clk_sys);
    eaValid  <= 1'b1;
    eaSpaceY <= y;
    eaWrite  <= w;
    eaReg    <= r;
    eaValue  <= v;
    eaStep   <= s;
    @(posedge clk_sys);
    eaValid  <= 1'b0;
    // released lines do not keep the last value
    eaValue  <= ~v;
    eaStep   <= ~s;
  endtask
endmodule

// file: tb/circular_buffer_address_modulo_chk.sv
`timescale 1ns/1ps
module circular_buffer_address_modulo_chk #(
  parameter ADDR_WIDTH = 16,
  parameter SEL_WIDTH  = 4
) (
  // clock and reset
  input wire                  clk_sys,
  input wire                  reset,
  // apb
  input wire                  psel,
  input wire                  penable,
  input wire                  pready,
  input wire                  pslverr,
  // update port
  input wire                  eaValid,
  input wire                  eaSpaceY,
  input wire                  eaWrite,
  input wire [SEL_WIDTH-1:0]  eaReg,
  input wire [ADDR_WIDTH-1:0] eaValue,
  input wire [ADDR_WIDTH-1:0] eaStep,
  input wire                  resultValid,
  input wire [SEL_WIDTH-1:0]  resultReg,
  input wire [ADDR_WIDTH-1:0] resultValue,
  input wire                  resultWrapped,
  input wire                  resultWrite
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // plain sum, word aligned in y space
  wire [ADDR_WIDTH-1:0] linSum = eaSpaceY ? ({eaValue[ADDR_WIDTH-1:1], 1'b0} + {eaStep[ADDR_WIDTH-1:1], 1'b0})
                                          : eaValue + eaStep;

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  chk_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error flag outside an access");
  chk_result_timing: assert property (eaValid |=> resultValid)
    else $error("no result one cycle after request");
  chk_result_quiet: assert property (!eaValid |=> !resultValid && !resultWrapped)
    else $error("result without request");
  chk_echo_fields: assert property (eaValid |=> resultReg == $past(eaReg) && resultWrite == $past(eaWrite))
    else $error("register or direction echo wrong");
  chk_y_word: assert property (eaValid && eaSpaceY |=> resultValue[0] == 1'b0)
    else $error("odd y space address");
  chk_linear_sum: assert property (eaValid ##1 !resultWrapped |-> resultValue == $past(linSum))
    else $error("unwrapped result is not the plain sum");

  cover property (eaValid ##1 resultWrapped);
  cover property (pslverr);
  cover property (eaValid && eaSpaceY ##1 resultWrapped);
endmodule

bind circular_buffer_address_modulo circular_buffer_address_modulo_chk #(
  .ADDR_WIDTH(ADDR_WIDTH), .SEL_WIDTH(SEL_WIDTH)) u_circular_buffer_address_modulo_chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .eaValid(eaValid), .eaSpaceY(eaSpaceY), .eaWrite(eaWrite), .eaReg(eaReg), .eaValue(eaValue), .eaStep(eaStep),
  .resultValid(resultValid), .resultReg(resultReg), .resultValue(resultValue), .resultWrapped(resultWrapped),
  .resultWrite(resultWrite));

// file: tb/circular_buffer_address_modulo_tb_top.sv
`timescale 1ns/1ps
`include "circ_addr_consts.vh"
module circular_buffer_address_modulo_tb_top;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, eaValid, eaSpaceY, eaWrite, resultValid, resultWrapped, resultWrite;
  wire  [3:0]  eaReg, resultReg;
  wire  [15:0] eaValue, eaStep, resultValue;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  logic        err;

  always #10 clk_sys = ~clk_sys;

  circular_buffer_address_modulo u_circular_buffer_address_modulo (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eaValid(eaValid),
    .eaSpaceY(eaSpaceY), .eaWrite(eaWrite), .eaReg(eaReg), .eaValue(eaValue), .eaStep(eaStep),
    .resultValid(resultValid), .resultReg(resultReg), .resultValue(resultValue),
    .resultWrapped(resultWrapped), .resultWrite(resultWrite));

  core_update_model u_core_update_model (
    .clk_sys(clk_sys), .eaValid(eaValid), .eaSpaceY(eaSpaceY), .eaWrite(eaWrite), .eaReg(eaReg),
    .eaValue(eaValue), .eaStep(eaStep));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    check("apb ready", 32'h1, {31'h0, pready});
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic regChk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
    apb(1'b0, addr, 32'h0);
    check("read data", exp, rd);
    check("slave error", {31'h0, expErr}, {31'h0, err});
  endtask

  task automatic upd(input logic y, input logic [3:0] r, input logic [15:0] v, input logic [15:0] s,
                     input logic [15:0] expV, input logic expW);
    u_core_update_model.issue(y, r[0], r, v, s);
    #1;
    check("result valid", 32'h1, {31'h0, resultValid});
    check("result value", {16'h0, expV}, {16'h0, resultValue});
    check("wrap flag", {31'h0, expW}, {31'h0, resultWrapped});
    check("result reg", {28'h0, r}, {28'h0, resultReg});
    check("result write", {31'h0, r[0]}, {31'h0, resultWrite});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++)
      regChk(12'(i * 4), 32'h0, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'hffff);
    regChk(`OFS_CONTROL, 32'hc0ff, 1'b0);
    regChk(12'h018, 32'h0, 1'b1);
    // x buffer of 50 words, incrementing only
    apb(1'b1, `OFS_X_START, 32'h1100);
    apb(1'b1, `OFS_X_END, 32'h1163);
    apb(1'b1, `OFS_CONTROL, 32'h8001);
    regChk(`OFS_X_END, 32'h1163, 1'b0);
    regChk(`OFS_STATUS, 32'h0031, 1'b0);
    upd(1'b0, 4'h1, 16'h1162, 16'h0002, 16'h1100, 1'b1);
    upd(1'b0, 4'h1, 16'h1110, 16'h0002, 16'h1112, 1'b0);
    upd(1'b0, 4'h2, 16'h1162, 16'h0002, 16'h1164, 1'b0);
    upd(1'b1, 4'h1, 16'h1162, 16'h0002, 16'h1164, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'h0001);
    upd(1'b0, 4'h1, 16'h1162, 16'h0002, 16'h1164, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'h800f);
    upd(1'b0, 4'hf, 16'h1162, 16'h0002, 16'h1164, 1'b0);
    // largest buffer spans the whole space
    apb(1'b1, `OFS_X_START, 32'h0000);
    apb(1'b1, `OFS_X_END, 32'hfffe);
    apb(1'b1, `OFS_CONTROL, 32'h8003);
    upd(1'b0, 4'h3, 16'h7ffe, 16'h0002, 16'h8000, 1'b0);
    upd(1'b0, 4'h3, 16'hfffe, 16'h0002, 16'h0000, 1'b1);
    // y buffer of 32 words, both directions
    apb(1'b1, `OFS_Y_START, 32'h2000);
    apb(1'b1, `OFS_Y_END, 32'h203f);
    apb(1'b1, `OFS_CONTROL, 32'h4010);
    regChk(`OFS_STATUS, 32'h007a, 1'b0);
    upd(1'b1, 4'h1, 16'h203e, 16'h0002, 16'h2000, 1'b1);
    upd(1'b1, 4'h1, 16'h2000, 16'hfffe, 16'h203e, 1'b1);
    upd(1'b1, 4'h1, 16'h2011, 16'h0003, 16'h2012, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'h40f0);
    upd(1'b1, 4'h1, 16'h203e, 16'h0002, 16'h2040, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'h8011);
    upd(1'b1, 4'h1, 16'h203e, 16'h0002, 16'h2040, 1'b0);
    // mid-run reset returns every writable register to zero
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    regChk(`OFS_CONTROL, 32'h0, 1'b0);
    regChk(`OFS_Y_END, 32'h0, 1'b0);
    regChk(`OFS_STATUS, 32'h0030, 1'b0);
    upd(1'b0, 4'h0, 16'h1162, 16'h0002, 16'h1164, 1'b0);
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end
endmodule
